//--- core/pmcs_pkg.sv
// Package: constants for the power management control/status register
// Assumes: a simple configuration access port clocked by mclk_i
package pmcs_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  PMCS_OFFSET        = 8'hE0;
    localparam int          PMCS_WIDTH         = 32;
    localparam int          WAKE_FLAG_BIT      = 15;
    localparam int          WAKE_ENABLE_BIT    = 8;
    localparam int          PSTATE_LSB         = 0;
    localparam int          PSTATE_MSB         = 1;
    localparam logic [1:0]  PSTATE_RESET       = 2'h0;
    localparam logic        WAKE_FLAG_RESET    = 1'h0;
    localparam logic        WAKE_ENABLE_RESET  = 1'h0;

    // ------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PMCS_D0 = 2'b00,
        PMCS_D1 = 2'b01,
        PMCS_D2 = 2'b10,
        PMCS_D3 = 2'b11
    } pmcs_pstate_t;
endpackage : pmcs_pkg

//--- core/pmcs_reg.sv
// File: power management control/status configuration register
// Assumes: host configuration accesses as one-cycle strobes on mclk_i
`timescale 1ns/10ps
`default_nettype none
module pmcs_reg
(
    input  wire logic                  mclk_i,
    input  wire logic                  arst_n_i,
    input  wire logic [7:0]            cfg_addr_i,
    input  wire logic                  cfg_wr_i,
    input  wire logic                  cfg_rd_i,
    input  wire logic [3:0]            cfg_be_i,
    input  wire logic [31:0]           cfg_wdata_i,
    output logic      [31:0]           cfg_rdata_o,
    input  wire logic                  wake_event_i,
    output pmcs_pkg::pmcs_pstate_t     power_state_o,
    output logic                       wake_notify_enable_o,
    output logic                       wake_event_flag_o,
    output logic                       wake_request_o
);
    import pmcs_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic         hit;
    logic         wr_lo;
    logic         wr_hi;
    logic         low_power;
    logic         wake_set;
    logic         wake_clr;
    logic [31:0]  read_word;
    pmcs_pstate_t pstate_reg;
    pmcs_pstate_t pstate_next;
    logic         enable_reg;
    logic         enable_next;
    logic [31:0]  rdata_reg;
    logic         flag;

    // ------------------------------------------------------------
    // Byte lane write decode
    // ------------------------------------------------------------
    function automatic logic lane_write(input logic [7:0] addr,
                                        input logic       strobe,
                                        input logic [3:0] be,
                                        input int         lane);
        return (addr == PMCS_OFFSET) && strobe && be[lane[1:0]];
    endfunction : lane_write

    assign hit       = (cfg_addr_i == PMCS_OFFSET);
    assign wr_lo     = lane_write(cfg_addr_i, cfg_wr_i, cfg_be_i, 0);
    assign wr_hi     = lane_write(cfg_addr_i, cfg_wr_i, cfg_be_i, 1);
    assign low_power = (pstate_reg != PMCS_D0);
    assign wake_set  = wake_event_i & low_power;
    assign wake_clr  = wr_hi & cfg_wdata_i[WAKE_FLAG_BIT];

    // ------------------------------------------------------------
    // Writable fields
    // ------------------------------------------------------------
    assign pstate_next = wr_lo
        ? pmcs_pstate_t'(cfg_wdata_i[PSTATE_MSB:PSTATE_LSB])
        : pstate_reg;
    assign enable_next = wr_hi ? cfg_wdata_i[WAKE_ENABLE_BIT] : enable_reg;

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pstate_reg <= PMCS_D0;
            enable_reg <= WAKE_ENABLE_RESET;
            rdata_reg  <= '0;
        end
        else
        begin
            pstate_reg <= pstate_next;
            enable_reg <= enable_next;
            rdata_reg  <= (hit & cfg_rd_i) ? read_word : 32'h0000_0000;
        end
    end

    pmcs_wake_flag u_flag (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .set_i    (wake_set),
        .clr_i    (wake_clr),
        .flag_o   (flag)
    );

    // ------------------------------------------------------------
    // Read word, fixed zero fields
    // ------------------------------------------------------------
    assign read_word = {8'h00,
                        8'h00,
                        flag,
                        2'h0,
                        4'h0,
                        enable_reg,
                        6'h00,
                        pstate_reg};

    assign cfg_rdata_o          = rdata_reg;
    assign power_state_o        = pstate_reg;
    assign wake_notify_enable_o = enable_reg;
    assign wake_event_flag_o    = flag;
    assign wake_request_o       = flag & enable_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_read_strobe;
        hit && cfg_rd_i;
    endsequence

    sequence s_clear_write;
        wake_clr && !wake_set;
    endsequence

    sequence s_set_and_clear;
        wake_set && wake_clr;
    endsequence

    sequence s_enabled_event;
        wake_set && wake_notify_enable_o && !wr_hi;
    endsequence

    sequence s_quiet_in_d0;
        wake_event_i && !low_power && !wake_event_flag_o;
    endsequence

    sequence s_no_state_write;
        !wr_lo;
    endsequence

    sequence s_no_enable_write;
        !wr_hi;
    endsequence

    AST_WAKE_SET: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        wake_set |=> wake_event_flag_o)
        else $error("wake flag not set");
    AST_SET_WINS: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        s_set_and_clear |=> wake_event_flag_o)
        else $error("clear beat a new wake event");
    AST_D0_IGNORE: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        s_quiet_in_d0 |=> !wake_event_flag_o)
        else $error("wake flag set in D0");
    AST_WAKE_CLR: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        s_clear_write |=> !wake_event_flag_o)
        else $error("wake flag not cleared");
    AST_WAKE_HOLD: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        (!wake_clr && wake_event_flag_o) |=> wake_event_flag_o)
        else $error("wake flag lost");
    AST_NOTIFY: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        wake_request_o |-> wake_notify_enable_o)
        else $error("notify without enable");
    AST_NOTIFY_ON: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        s_enabled_event |=> wake_request_o)
        else $error("enabled wake event not notified");
    AST_ENABLE_WR: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        wr_hi |=>
            wake_notify_enable_o == $past(cfg_wdata_i[WAKE_ENABLE_BIT]))
        else $error("notify enable not written");
    AST_ENABLE_KEEP: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        s_no_enable_write |=> $stable(wake_notify_enable_o))
        else $error("notify enable changed without write");
    AST_PSTATE: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        wr_lo |=>
            power_state_o == $past(cfg_wdata_i[PSTATE_MSB:PSTATE_LSB]))
        else $error("power state not written");
    AST_PSTATE_KEEP: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        s_no_state_write |=> $stable(power_state_o))
        else $error("power state changed without write");
    AST_RD_STATE: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        s_read_strobe |=>
            cfg_rdata_o[PSTATE_MSB:PSTATE_LSB] == $past(power_state_o))
        else $error("power state read back wrong");
    AST_RD_FLAG: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        s_read_strobe |=>
            cfg_rdata_o[WAKE_FLAG_BIT] == $past(wake_event_flag_o))
        else $error("wake flag read back wrong");
    AST_RD_ENABLE: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        s_read_strobe |=>
            cfg_rdata_o[WAKE_ENABLE_BIT] == $past(wake_notify_enable_o))
        else $error("notify enable read back wrong");
    AST_HI_ZERO: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        cfg_rdata_o[31:24] == 8'h00)
        else $error("power data field not zero");
    AST_BRIDGE: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        cfg_rdata_o[23:16] == 8'h00)
        else $error("bridge field not zero");
    AST_SCALE_SEL: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        cfg_rdata_o[14:13] == 2'h0)
        else $error("scale field not zero");
    AST_SELECT: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        cfg_rdata_o[12:9] == 4'h0)
        else $error("select field not zero");
    AST_RSVD: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        cfg_rdata_o[7:2] == 6'h00)
        else $error("reserved bits not zero");
    AST_IDLE_ZERO: assert property (@(posedge mclk_i)
        disable iff (!arst_n_i)
        !(hit && cfg_rd_i) |=> cfg_rdata_o == 32'h0000_0000)
        else $error("read data without a read");
    AST_RESET_D0: assert property (@(posedge mclk_i)
        !arst_n_i |=> power_state_o == PMCS_D0 || !arst_n_i)
        else $error("power state not D0 after reset");
endmodule : pmcs_reg
`default_nettype wire

//--- core/pmcs_wake_flag.sv
// Module: sticky wake event flag, write-one-to-clear
// Assumes: event and clear strobes synchronous to mclk_i
`timescale 1ns/10ps
`default_nettype none
module pmcs_wake_flag
(
    input  wire logic mclk_i,
    input  wire logic arst_n_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    import pmcs_pkg::*;

    logic flag_reg;
    logic flag_next;

    // ------------------------------------------------------------
    // Set wins over clear
    // ------------------------------------------------------------
    assign flag_next = set_i | (flag_reg & ~clr_i);

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            flag_reg <= WAKE_FLAG_RESET;
        else
            flag_reg <= flag_next;
    end

    assign flag_o = flag_reg;
endmodule : pmcs_wake_flag
`default_nettype wire

//--- test/pmcs_host_model.sv
// Host model: config reads and writes as one-cycle strobes
// Assumes: first call is made after reset release
`timescale 1ns/10ps
`default_nettype none
module pmcs_host_model (
    input  wire logic        mclk_i,
    input  wire logic [31:0] rdata_i,
    output logic      [7:0]  addr_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [3:0]  be_o,
    output logic      [31:0] wdata_o
);
    initial
    begin
        {addr_o, wr_o, rd_o, be_o, wdata_o} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
        @(posedge mclk_i);
        #1;
        {addr_o, be_o, wdata_o, wr_o} = {a, b, d, 1'b1};
        @(posedge mclk_i);
        #1;
        {addr_o, be_o, wdata_o, wr_o} = {~a, ~b, ~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        #1;
        {addr_o, rd_o} = {a, 1'b1};
        @(posedge mclk_i);
        #1;
        {addr_o, rd_o} = {~a, 1'b0};
        d = rdata_i;
    endtask : rd
endmodule : pmcs_host_model
`default_nettype wire

//--- test/tb_top.sv
// Testbench: config accesses and wake events on the status register
// Assumes: design files and host model compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import pmcs_pkg::*;
    logic         mclk = 1'b0;
    logic         arst_n = 1'b0;
    logic         wake = 1'b0;
    logic         wr, rd, en, flag, req;
    logic  [7:0]  addr;
    logic  [3:0]  be;
    logic  [31:0] wdata, rdata, rv;
    pmcs_pstate_t pst;
    int           fail_count = 0;
    int           checks_done = 0;
    wire   [31:0] stv = {27'h0, pst, en, flag, req};
    pmcs_reg dut_u (.mclk_i(mclk), .arst_n_i(arst_n), .cfg_addr_i(addr),
        .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_be_i(be), .cfg_wdata_i(wdata),
        .cfg_rdata_o(rdata), .wake_event_i(wake), .power_state_o(pst),
        .wake_notify_enable_o(en), .wake_event_flag_o(flag),
        .wake_request_o(req));
    pmcs_host_model host_u (.mclk_i(mclk), .rdata_i(rdata), .addr_o(addr),
        .wr_o(wr), .rd_o(rd), .be_o(be), .wdata_o(wdata));
    initial
    begin
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse;
        @(posedge mclk);
        #1;
        wake = 1'b1;
        @(posedge mclk);
        #1;
        wake = 1'b0;
    endtask : pulse
    task automatic t_reset;
        host_u.rd(PMCS_OFFSET, rv);
        chk(rv, 32'h0);
        chk(stv, 32'h0);
    endtask : t_reset
    task automatic t_pstate;
        for (int s = 0; s < 4; s++)
        begin
            host_u.wr(PMCS_OFFSET, 4'hF, 32'hFFFF7EFC | 32'(s));
            host_u.rd(PMCS_OFFSET, rv);
            chk(rv, 32'(s));
        end
        host_u.wr(PMCS_OFFSET, 4'hE, 32'hFFFF_7EFC);
        host_u.rd(PMCS_OFFSET, rv);
        chk(rv, 32'h3);
        host_u.wr(8'hE4, 4'hF, 32'h0000_0100);
        host_u.rd(8'hE4, rv);
        chk(rv, 32'h0);
        chk(stv, 32'h18);
    endtask : t_pstate
    task automatic t_wake;
        pulse();
        chk(stv, 32'h1A);
        host_u.wr(PMCS_OFFSET, 4'hF, 32'h0000_0103);
        chk(stv, 32'h1F);
        host_u.rd(PMCS_OFFSET, rv);
        chk(rv, 32'h0000_8103);
        fork
            host_u.wr(PMCS_OFFSET, 4'hF, 32'h0000_8103);
            pulse();
        join
        chk(stv, 32'h1F);
        host_u.wr(PMCS_OFFSET, 4'hF, 32'h0000_8100);
        chk(stv, 32'h04);
        pulse();
        chk(stv, 32'h04);
    endtask : t_wake
    task automatic t_midreset;
        host_u.wr(PMCS_OFFSET, 4'hF, 32'h0000_0102);
        pulse();
        chk(stv, 32'h17);
        @(posedge mclk);
        #1;
        arst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        arst_n = 1'b1;
        chk(stv, 32'h0);
        host_u.rd(PMCS_OFFSET, rv);
        chk(rv, 32'h0);
    endtask : t_midreset
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (16) @(posedge mclk);
        #1;
        arst_n = 1'b1;
        t_reset();
        t_pstate();
        t_wake();
        t_midreset();
        wrap_up();
    end
    initial
    begin
        #20000;
        fail_count++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
